/* common/fps_pkg.sv */
// Package for the flash program/erase sequencer: map, fields, reset values
package fps_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL_A   = 8'h00; // flash_ctrl_reg_a
    localparam logic [7:0] OFS_CTRL_B   = 8'h04; // flash_ctrl_reg_b
    localparam logic [7:0] OFS_EBSEL_A  = 8'h08; // erase_block_sel_a
    localparam logic [7:0] OFS_EBSEL_B  = 8'h0C; // erase_block_sel_b
    localparam logic [7:0] OFS_WD_PER   = 8'h10;
    localparam logic [7:0] OFS_WD_CTRL  = 8'h14;
    localparam logic [7:0] OFS_VADDR    = 8'h18;
    localparam logic [7:0] OFS_VDATA    = 8'h1C;
    localparam logic [7:0] OFS_CALC_SRC = 8'h20;
    localparam logic [7:0] OFS_CALC_VER = 8'h24;
    localparam logic [7:0] OFS_CALC_PRV = 8'h28;
    localparam logic [7:0] OFS_CALC_RES = 8'h2C;
    localparam logic [7:0] OFS_LOOP     = 8'h30;
    localparam logic [7:0] OFS_STATUS   = 8'h34;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int WD_ARM_BIT    = 0;
    localparam int WD_OVF_BIT    = 1;
    localparam int LOOP_CLR_BIT  = 0;
    localparam int LOOP_STEP_BIT = 1;
    localparam int LOOP_ADD_BIT  = 16;
    localparam int LOOP_FAIL_BIT = 17;
    localparam int RES_ADD_LSB   = 16;
    localparam int CTRL_W        = 7;
    localparam int ADD_LOOP_LO   = 1;
    localparam int ADD_LOOP_HI   = 6;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] WD_PER_RST = 32'h0000_FFFF;
    localparam logic [15:0] ERASED_WRD = 16'hFFFF;
    localparam logic [7:0]  DUMMY_BYTE = 8'hFF;

    // Flash control bits, one copy per register, bit 6 down to bit 0
    typedef struct packed {
        logic swe; // sw_write_enable
        logic esu; // erase_setup
        logic psu; // program setup
        logic ev;  // erase_verify
        logic pv;  // program verify
        logic e;   // erase_active
        logic p;   // program_pulse
    } fps_fctl_t;

    localparam fps_fctl_t CTRL_RST = 7'h00;

endpackage

/* sim/flash_program_erase_sequencer_bench.sv */
// Self-checking bench for the flash program/erase sequencer
module flash_program_erase_sequencer_bench
    import fps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest, wd_overflow;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    fps_fctl_t   fl_ctrl;
    logic [15:0] fl_blk_sel, fl_rdata;
    logic [18:0] fl_addr;
    int          n_errors = 0;
    int          check_count = 0;
    int          cycles = 0;

    fps_flash_seq #(.MAX_LOOP(8)) DUT (
        .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .avs_address_i(avs_address),
        .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
        .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest),
        .fl_ctrl_o(fl_ctrl), .fl_blk_sel_o(fl_blk_sel), .fl_addr_o(fl_addr),
        .fl_rdata_i(fl_rdata), .wd_overflow_o(wd_overflow));

    fps_flash_model u_model (
        .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .fl_ctrl_i(fl_ctrl),
        .fl_blk_sel_i(fl_blk_sel), .fl_addr_i(fl_addr), .fl_rdata_o(fl_rdata));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Tests need well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic final_report();
        $display("errors=%0d checks=%0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Request held until the edge that samples waitrequest low
    task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr_en;
        avs_read      <= !wr_en;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    // Both control registers, A then B in two writes, then the gated array bits
    task automatic ctl(input logic [31:0] a, input logic [31:0] b, input logic [6:0] exp);
        wr(OFS_CTRL_A, a);
        wr(OFS_CTRL_B, b);
        @(posedge sys_clk);
        chk({25'h0, fl_ctrl}, {25'h0, exp});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0000_0000;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rdchk(OFS_CTRL_A, 32'h0000_0000);
        rdchk(OFS_EBSEL_B, 32'h0000_0000);
        rdchk(OFS_WD_PER, 32'h0000_FFFF);
        rdchk(OFS_CALC_RES, 32'hFFFF_FFFF);
        rdchk(OFS_LOOP, 32'h0000_0000);
        wr(8'h3C, 32'h1234_5678);
        rdchk(8'h3C, 32'h0000_0000);
        // Reprogram and additional data over all bit combinations
        wr(OFS_CALC_SRC, 32'h0000_3333);
        wr(OFS_CALC_VER, 32'h0000_5555);
        wr(OFS_CALC_PRV, 32'h0000_0F0F);
        rdchk(OFS_CALC_RES, {~(~16'h0F0F & ~16'h5555), ~(~16'h3333 & 16'h5555)});
        // Loop count, additional window and failure at the limit
        wr(OFS_LOOP, 32'h0000_0001);
        for (int i = 1; i <= 8; i++) begin
            wr(OFS_LOOP, 32'h0000_0002);
            rdchk(OFS_LOOP, 32'(i) | ((i <= 6) ? 32'h0001_0000 : 32'h0000_0000));
        end
        wr(OFS_LOOP, 32'h0000_0002);
        rdchk(OFS_LOOP, 32'h0002_0008);
        wr(OFS_LOOP, 32'h0000_0001);
        rdchk(OFS_LOOP, 32'h0000_0000);
        // Single-block erase with watchdog armed
        ctl(32'h0000_0040, 32'h0000_0040, 7'h40);
        wr(OFS_EBSEL_A, 32'h0000_0001);
        wr(OFS_WD_PER, 32'h0000_00C8);
        wr(OFS_WD_CTRL, 32'h0000_0001);
        ctl(32'h0000_0060, 32'h0000_0060, 7'h60);
        ctl(32'h0000_0062, 32'h0000_0060, 7'h60);
        wr(OFS_CTRL_B, 32'h0000_0062);
        @(posedge sys_clk);
        chk({25'h0, fl_ctrl}, 32'h0000_0062);
        wr(OFS_EBSEL_B, 32'h0000_0001);
        @(posedge sys_clk);
        chk({25'h0, fl_ctrl}, 32'h0000_0060);
        wr(OFS_EBSEL_B, 32'h0000_0000);
        repeat (10) @(posedge sys_clk);
        ctl(32'h0000_0060, 32'h0000_0060, 7'h60);
        ctl(32'h0000_0040, 32'h0000_0040, 7'h40);
        repeat (250) @(posedge sys_clk);
        chk({31'h0, wd_overflow}, 32'h0000_0000);
        rdchk(OFS_WD_CTRL, 32'h0000_0000);
        // Erase-verify over two addresses
        ctl(32'h0000_0048, 32'h0000_0048, 7'h48);
        wr(OFS_VADDR, 32'h0001_02FF);
        @(posedge sys_clk);
        chk({13'h0, fl_addr}, 32'h0000_0102);
        bus(1'b0, OFS_STATUS, 32'h0000_0000);
        chk(rd & 32'h0000_0010, 32'h0000_0010);
        rdchk(OFS_VDATA, {16'h0, ERASED_WRD});
        wr(OFS_VADDR, 32'h0001_04FF);
        @(posedge sys_clk);
        chk({13'h0, fl_addr}, 32'h0000_0104);
        rdchk(OFS_VDATA, {16'h0, ERASED_WRD});
        ctl(32'h0000_0040, 32'h0000_0040, 7'h40);
        rdchk(OFS_VDATA, 32'h0000_0000);
        ctl(32'h0000_0000, 32'h0000_0000, 7'h00);
        // Program one unit at a 0x80 boundary; program-setup exit disarms the watchdog
        ctl(32'h0000_0040, 32'h0000_0040, 7'h40);
        wr(OFS_VADDR, 32'h0000_80FF);
        wr(OFS_WD_CTRL, 32'h0000_0001);
        ctl(32'h0000_0050, 32'h0000_0050, 7'h50);
        ctl(32'h0000_0051, 32'h0000_0051, 7'h51);
        repeat (30) @(posedge sys_clk);
        chk({25'h0, fl_ctrl}, 32'h0000_0051);
        ctl(32'h0000_0050, 32'h0000_0050, 7'h50);
        ctl(32'h0000_0040, 32'h0000_0040, 7'h40);
        rdchk(OFS_WD_CTRL, 32'h0000_0000);
        ctl(32'h0000_0044, 32'h0000_0044, 7'h44);
        rdchk(OFS_VDATA, {16'h0, 16'h0080 ^ 16'hA5A5});
        // Top block (select bit 15) on its own, erased and read back erased at the area programmed above
        ctl(32'h0000_0040, 32'h0000_0040, 7'h40);
        wr(OFS_EBSEL_A, 32'h0000_0000);
        wr(OFS_EBSEL_B, 32'h0000_0080);
        wr(OFS_WD_CTRL, 32'h0000_0001);
        ctl(32'h0000_0060, 32'h0000_0060, 7'h60);
        chk({16'h0, fl_blk_sel}, 32'h0000_8000);
        ctl(32'h0000_0062, 32'h0000_0062, 7'h62);
        ctl(32'h0000_0060, 32'h0000_0060, 7'h60);
        ctl(32'h0000_0048, 32'h0000_0048, 7'h48);
        rdchk(OFS_WD_CTRL, 32'h0000_0000);
        wr(OFS_VADDR, 32'h0000_80FF);
        rdchk(OFS_VDATA, {16'h0, ERASED_WRD});
        ctl(32'h0000_0040, 32'h0000_0040, 7'h40);
        ctl(32'h0000_0000, 32'h0000_0000, 7'h00);
        // Runaway: watchdog expires during setup
        wr(OFS_WD_PER, 32'h0000_0014);
        wr(OFS_WD_CTRL, 32'h0000_0001);
        ctl(32'h0000_0060, 32'h0000_0060, 7'h60);
        repeat (30) @(posedge sys_clk);
        chk({31'h0, wd_overflow}, 32'h0000_0001);
        chk({25'h0, fl_ctrl}, 32'h0000_0000);
        rdchk(OFS_CTRL_A, 32'h0000_0000);
        rdchk(OFS_WD_CTRL, 32'h0000_0002);
        wr(OFS_WD_CTRL, 32'h0000_0002);
        @(posedge sys_clk);
        chk({31'h0, wd_overflow}, 32'h0000_0000);
        final_report();
    end
endmodule

/* sim/fps_flash_model.sv */
// Behavioural model of the flash array behind the sequencer
module fps_flash_model
    import fps_pkg::*;
#(
    parameter int FL_AW = 19
) (
    input  wire logic             sys_clk_i,
    input  wire logic             sys_rst_i,
    input  wire fps_fctl_t        fl_ctrl_i,
    input  wire logic [15:0]      fl_blk_sel_i,
    input  wire logic [FL_AW-1:0] fl_addr_i,
    output logic      [15:0]      fl_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic erased_r;

    // ------------------------------------------------------------
    // Array state
    // ------------------------------------------------------------
    // No preprogramming needed; the block erases only while erase is on
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            erased_r <= 1'b0;
        end else if (fl_ctrl_i.e && (|fl_blk_sel_i)) begin
            erased_r <= 1'b1;
        end else if (fl_ctrl_i.p) begin
            erased_r <= 1'b0;
        end
    end

    // Unerased cells give an address pattern, all ones only where the low 16 address bits are 5A5A
    assign fl_rdata_o = erased_r ? ERASED_WRD : (fl_addr_i[15:0] ^ 16'hA5A5);
endmodule

/* verilog/fps_flash_seq.sv */
// Flash program/erase sequencer with Avalon-MM register slave
// Operation
// - Erase lasts exactly while erase bits are set, within the maximum.
// - Erase works without preprogramming the block to zeros.
// - Leaving erase mode cancels the watchdog arming.
// - After the delay, 16-bit reads return data at the latched address.
//
// Our own choices: the address map and the Avalon-MM register port.
module fps_flash_seq
    import fps_pkg::*;
#(
    parameter int BLK_A_W  = 8,
    parameter int BLK_B_W  = 8,
    parameter int FL_AW    = 19,
    parameter int LOOP_W   = 10,
    parameter int MAX_LOOP = 1000
) (
    input  wire logic                       sys_clk_i,
    input  wire logic                       sys_rst_i,
    input  wire logic [7:0]                 avs_address_i,
    input  wire logic                       avs_read_i,
    input  wire logic                       avs_write_i,
    input  wire logic [31:0]                avs_writedata_i,
    output logic      [31:0]                avs_readdata_o,
    output logic                            avs_waitrequest_o,
    output fps_fctl_t                       fl_ctrl_o,
    output logic [BLK_A_W+BLK_B_W-1:0]      fl_blk_sel_o,
    output logic [FL_AW-1:0]                fl_addr_o,
    input  wire logic [15:0]                fl_rdata_i,
    output logic                            wd_overflow_o
);

    if (BLK_A_W < 1 || BLK_A_W > 16 || BLK_B_W < 1 || BLK_B_W > 16 || FL_AW < 1 || FL_AW > 24 ||
        LOOP_W < 3 || LOOP_W > 16 || MAX_LOOP < 1 || MAX_LOOP >= (1 << LOOP_W)) begin
        $error("fps_flash_seq: unsupported parameter values");
    end

    localparam logic [LOOP_W-1:0] LOOP_MAX = LOOP_W'(MAX_LOOP);
    localparam logic [LOOP_W-1:0] LOOP_LO  = LOOP_W'(ADD_LOOP_LO);
    localparam logic [LOOP_W-1:0] LOOP_HI  = LOOP_W'(ADD_LOOP_HI);

    // ----------------------------------------------------------------
    // Bus slave: one wait state on every access
    // ----------------------------------------------------------------
    logic ack_r;
    logic [31:0] rdata_r;
    wire  req   = avs_read_i | avs_write_i;
    wire  wr_go = avs_write_i & ack_r;
    wire  rd_go = avs_read_i & ~ack_r;
    wire  w_ca  = wr_go & (avs_address_i == OFS_CTRL_A);
    wire  w_cb  = wr_go & (avs_address_i == OFS_CTRL_B);
    wire  w_ea  = wr_go & (avs_address_i == OFS_EBSEL_A);
    wire  w_eb  = wr_go & (avs_address_i == OFS_EBSEL_B);
    wire  w_wp  = wr_go & (avs_address_i == OFS_WD_PER);
    wire  w_wc  = wr_go & (avs_address_i == OFS_WD_CTRL);
    wire  w_va  = wr_go & (avs_address_i == OFS_VADDR);
    wire  w_cs  = wr_go & (avs_address_i == OFS_CALC_SRC);
    wire  w_cv  = wr_go & (avs_address_i == OFS_CALC_VER);
    wire  w_cp  = wr_go & (avs_address_i == OFS_CALC_PRV);
    wire  w_lp  = wr_go & (avs_address_i == OFS_LOOP);

    assign avs_waitrequest_o = req & ~ack_r;
    assign avs_readdata_o    = rdata_r;

    // ----------------------------------------------------------------
    // Control state
    // ----------------------------------------------------------------
    fps_fctl_t           ctrl_a_r, ctrl_b_r;
    logic [BLK_A_W-1:0]  sel_a_r;
    logic [BLK_B_W-1:0]  sel_b_r;
    logic [31:0]         wd_per_r, wd_cnt_r;
    logic                wd_arm_r, wd_ovf_r;
    logic                esu_q_r, psu_q_r;
    logic                dummy_ok_r;
    logic [FL_AW-1:0]    vaddr_r;
    logic [15:0]         src_r, ver_r, prv_r;
    logic [LOOP_W-1:0]   loop_r;
    logic                fail_r;

    fps_fctl_t both;
    assign both = ctrl_a_r & ctrl_b_r;

    wire [BLK_A_W+BLK_B_W-1:0] sel_all = {sel_b_r, sel_a_r};
    wire sel_one  = (sel_all != '0) && ((sel_all & (sel_all - 1'b1)) == '0);
    wire esu_fall = esu_q_r & ~both.esu;
    wire psu_fall = psu_q_r & ~both.psu;
    wire wd_fire  = wd_arm_r & (wd_cnt_r >= wd_per_r);
    // Erase only while both erase bits are held; block contents never gate it
    wire erase_on = both.e & both.esu & both.swe & sel_one & ~wd_ovf_r;
    wire prog_on  = both.p & both.psu & both.swe & ~wd_ovf_r;
    wire vmode    = both.ev | both.pv;

    always_comb begin
        fl_ctrl_o     = both;
        fl_ctrl_o.e   = erase_on;
        fl_ctrl_o.p   = prog_on;
    end
    assign fl_blk_sel_o  = sel_all;
    assign fl_addr_o     = vaddr_r;
    assign wd_overflow_o = wd_ovf_r;

    // ----------------------------------------------------------------
    // Verify data helpers
    // ----------------------------------------------------------------
    wire [15:0] reprog  = src_r | ~ver_r;
    wire [15:0] addprog = prv_r | ver_r;
    wire add_ok   = (loop_r >= LOOP_LO) && (loop_r <= LOOP_HI);
    wire loop_clr = w_lp & avs_writedata_i[LOOP_CLR_BIT];
    wire loop_stp = w_lp & avs_writedata_i[LOOP_STEP_BIT] & ~avs_writedata_i[LOOP_CLR_BIT];
    wire at_max   = (loop_r == LOOP_MAX);

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        unique case (avs_address_i)
            OFS_CTRL_A:   rd_mux = 32'(ctrl_a_r);
            OFS_CTRL_B:   rd_mux = 32'(ctrl_b_r);
            OFS_EBSEL_A:  rd_mux = 32'(sel_a_r);
            OFS_EBSEL_B:  rd_mux = 32'(sel_b_r);
            OFS_WD_PER:   rd_mux = wd_per_r;
            OFS_WD_CTRL:  rd_mux = 32'({wd_ovf_r, wd_arm_r});
            OFS_VADDR:    rd_mux = 32'(vaddr_r);
            OFS_VDATA:    rd_mux = vmode ? 32'(fl_rdata_i) : '0;
            OFS_CALC_SRC: rd_mux = 32'(src_r);
            OFS_CALC_VER: rd_mux = 32'(ver_r);
            OFS_CALC_PRV: rd_mux = 32'(prv_r);
            OFS_CALC_RES: rd_mux = {addprog, reprog};
            OFS_LOOP:     rd_mux = {14'h0000, fail_r, add_ok, 16'(loop_r)};
            OFS_STATUS:   rd_mux = 32'({dummy_ok_r, sel_one, vmode, prog_on, erase_on});
            default:      rd_mux = '0;
        endcase
    end

    // ----------------------------------------------------------------
    // Bus handshake and read data
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ack_r   <= 1'b0;
            rdata_r <= '0;
        end else begin
            ack_r <= req & ~ack_r;
            if (rd_go) begin
                rdata_r <= rd_mux;
            end
        end
    end

    // ----------------------------------------------------------------
    // Flash control bits; an overflow drops every mode at once
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || wd_fire) begin
            ctrl_a_r <= CTRL_RST;
            ctrl_b_r <= CTRL_RST;
        end else begin
            if (w_ca) begin
                ctrl_a_r <= fps_fctl_t'(avs_writedata_i[CTRL_W-1:0]);
            end
            if (w_cb) begin
                ctrl_b_r <= fps_fctl_t'(avs_writedata_i[CTRL_W-1:0]);
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sel_a_r <= '0;
            sel_b_r <= '0;
            esu_q_r <= 1'b0;
            psu_q_r <= 1'b0;
        end else begin
            esu_q_r <= both.esu;
            psu_q_r <= both.psu;
            if (w_ea) begin
                sel_a_r <= avs_writedata_i[BLK_A_W-1:0];
            end
            if (w_eb) begin
                sel_b_r <= avs_writedata_i[BLK_B_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Runaway watchdog
    // ----------------------------------------------------------------
    wire ovf_clr = w_wc & avs_writedata_i[WD_OVF_BIT];
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            wd_per_r <= WD_PER_RST;
            wd_cnt_r <= '0;
            wd_arm_r <= 1'b0;
            wd_ovf_r <= 1'b0;
        end else begin
            if (w_wp) begin
                wd_per_r <= avs_writedata_i;
            end
            // Set wins over a clear landing in the same cycle
            wd_ovf_r <= wd_fire | (wd_ovf_r & ~ovf_clr);
            if (wd_fire || esu_fall || psu_fall) begin
                wd_arm_r <= 1'b0;
                wd_cnt_r <= '0;
            end else if (w_wc) begin
                wd_arm_r <= avs_writedata_i[WD_ARM_BIT];
                wd_cnt_r <= '0;
            end else if (wd_arm_r) begin
                wd_cnt_r <= wd_cnt_r + 32'h0000_0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Verify address latch, operand registers, loop counter
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            vaddr_r    <= '0;
            dummy_ok_r <= 1'b0;
            src_r      <= ERASED_WRD;
            ver_r      <= ERASED_WRD;
            prv_r      <= ERASED_WRD;
        end else begin
            if (w_va) begin
                vaddr_r    <= avs_writedata_i[FL_AW+7:8];
                dummy_ok_r <= (avs_writedata_i[7:0] == DUMMY_BYTE);
            end
            if (w_cs) begin
                src_r <= avs_writedata_i[15:0];
            end
            if (w_cv) begin
                ver_r <= avs_writedata_i[15:0];
            end
            if (w_cp) begin
                prv_r <= avs_writedata_i[15:0];
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            loop_r <= '0;
            fail_r <= 1'b0;
        end else if (loop_clr) begin
            loop_r <= '0;
            fail_r <= 1'b0;
        end else if (loop_stp) begin
            if (at_max) begin
                fail_r <= 1'b1;
            end else begin
                loop_r <= loop_r + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_vread;
        (avs_read_i && avs_waitrequest_o && avs_address_i == OFS_VDATA && vmode) ##1 !avs_waitrequest_o;
    endsequence
    AST_ERASE_NEEDS_BITS: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        fl_ctrl_o.e |-> (ctrl_a_r.e && ctrl_b_r.e && sel_one))
        else $error("erase driven without both erase bits and one block");
    AST_ERASE_STOPS: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (w_ca && !avs_writedata_i[1]) |=> !fl_ctrl_o.e)
        else $error("erase continued after erase bit cleared");
    AST_ERASE_NO_PREPROG: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (ctrl_a_r.e && ctrl_b_r.e && ctrl_a_r.esu && ctrl_b_r.esu && ctrl_a_r.swe && ctrl_b_r.swe &&
         sel_one && !wd_overflow_o) |-> fl_ctrl_o.e)
        else $error("erase refused with valid settings");
    AST_WD_DISARM: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $fell(both.esu) |=> !wd_arm_r)
        else $error("watchdog still armed after erase exit");
    AST_VERIFY_READ: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        s_vread |-> avs_readdata_o[15:0] == $past(fl_rdata_i))
        else $error("verify read not from latched flash data");
    AST_WD_ABORT: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        wd_fire |=> (fl_ctrl_o == CTRL_RST && wd_ovf_r))
        else $error("watchdog overflow did not abort");

endmodule
